//--- bench/bcs_charger_test.sv
// Self-checking bench for the charge sequencer.
// Assumes zero-wait APB and shortened soft, qualify and slow-step counts.
`timescale 1ns/1ps
module bcs_charger_test;
   import bcs_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        pwm_out, discharge_drive, err_q;
   logic        dm_pd, dm_pu, ch_pd, ch_pu, sup, tmo, t_over, t_win;
   logic [11:0] paddr, cell_set, cs_set, cell_v, cur_s;
   logic [31:0] pwdata, prdata, q;
   int          n_errors, comparisons, i, n;

   bcs_charger #(.SOFT_CYC_P(40'h0c8), .QUAL_CYC_P(40'h064),
      .SLOW_STEP_CYC_P(32'h4)) bcs_charger_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .discharge_maint_select_pd(dm_pd), .discharge_maint_select_pu(dm_pu),
      .chemistry_select_pd(ch_pd), .chemistry_select_pu(ch_pu),
      .supply_or_cell_select(sup), .timeout_rc_select(tmo),
      .temp_over(t_over), .temp_in_window(t_win),
      .cell_voltage_sense(cell_v), .current_sense(cur_s),
      .pwm_out(pwm_out), .discharge_drive(discharge_drive));
   bcs_stage_model bcs_stage_model_inst (.pclk(pclk), .presetn(presetn),
      .discharge_drive(discharge_drive), .cell_set(cell_set),
      .cs_set(cs_set), .cell_voltage_sense(cell_v), .current_sense(cur_s));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Poll status with a bounded count; the phases here last a few hundred
   task ws(input bcs_state_type s);
      i = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         i++;
      end while (q[10:0] !== s && i < 600);
      chk(32'(q[10:0]), 32'(s));
   endtask

   task cfg(input logic [4:0] p, input logic [11:0] c);
      {dm_pd, dm_pu, ch_pd, ch_pu, sup} <= p;
      cell_set <= c; cs_set <= 12'h5dc; tmo <= 1'b0;
      t_over <= 1'b0; t_win <= 1'b1; presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task end_sim;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #900_000;
      n_errors++;
      end_sim;
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; cell_set = 12'h000;
      cs_set = 12'h5dc; {dm_pd, dm_pu, ch_pd, ch_pu, sup} = 5'h1f;
      tmo = 1'b0; t_over = 1'b0; t_win = 1'b0;
      n_errors = 0; comparisons = 0;
      // Ni-MH, no discharge, fast supply
      cfg(5'h1f, 12'h000);
      t_win <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0); chk(q, 32'(CTRL_RST));
      ws(ST_IDLE); chk({pwm_out, discharge_drive}, 2'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(q, 32'h0);
      chk(err_q, 1'b1);
      cell_set <= 12'h514;
      repeat (40) @(posedge pclk);
      ws(ST_IDLE);
      t_win <= 1'b1;
      ws(ST_SOFT);
      ws(ST_FAST);
      repeat (4) @(posedge pclk);
      chk(pwm_out, 1'b1);
      cell_set <= 12'h5dc;
      repeat (6) @(posedge pclk);
      cell_set <= 12'h5c8;
      ws(ST_TOPUP);
      tmo <= 1'b1;
      ws(ST_MAINT);
      $display("nimh sequence done");
      // Ni-Cd: 20 mV drop is too small, then over-temperature
      cfg(5'h18, 12'h5dc);
      ws(ST_FAST);
      cell_set <= 12'h5c8;
      repeat (20) @(posedge pclk);
      ws(ST_FAST);
      t_over <= 1'b1;
      ws(ST_ERR);
      apb(1'b0, ADDR_ERR, 32'h0); chk(q[2:0], 3'h4);
      apb(1'b1, ADDR_ERR, 32'h4);
      apb(1'b0, ADDR_ERR, 32'h0);
      chk(q[2:0], 3'h0);
      t_over <= 1'b0;
      ws(ST_SOFT);
      $display("nicd sequence done");
      // Soft start over-voltage, then bad battery
      cfg(5'h1f, 12'hc1c);
      ws(ST_ERR);
      repeat (50) @(posedge pclk);
      ws(ST_ERR);
      cell_set <= 12'h1f4;
      ws(ST_IDLE);
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(q, 32'h2);
      cfg(5'h1f, 12'h44c);
      ws(ST_SOFT);
      ws(ST_ERR);
      $display("soft start errors done");
      // Discharge before charge
      cfg(5'h0f, 12'h708);
      ws(ST_DISCH); chk(discharge_drive, 1'b1);
      chk(32'(q[14:13]), 32'(LVL_FLOAT));
      ws(ST_SOFT); chk(discharge_drive, 1'b0);
      // Maintenance only on a slow constant-current source: 8/256 duty
      cfg(5'h00, 12'h514);
      ws(ST_MAINT);
      chk(q[11], 1'b0);
      apb(1'b0, ADDR_LEVEL, 32'h0);
      chk(q, 32'h05dc_0514);
      n = 0;
      repeat (1024) begin
         @(posedge pclk);
         n += int'(pwm_out);
      end
      chk(n, 32);
      $display("discharge and maintenance done");
      // Li-Ion: qualification failure, then 4.1 V cell run
      cfg(5'h1d, 12'h44c);
      ws(ST_QUAL);
      ws(ST_ERR);
      cfg(5'h1c, 12'h5dc);
      ws(ST_QUAL);
      ws(ST_LCC); chk(pwm_out, 1'b1);
      chk(q[11], 1'b1);
      cell_set <= 12'ha64;
      repeat (20) @(posedge pclk);
      ws(ST_LCC);
      cell_set <= 12'ha78;
      ws(ST_LCV);
      cs_set <= 12'h8fc;
      ws(ST_MAINT);
      // Li-Ion 4.2 V cell, select low restarts on discharge
      cfg(5'h05, 12'h5dc);
      ws(ST_LCC);
      cell_set <= 12'hab9;
      ws(ST_LCV);
      cs_set <= 12'h8fc;
      ws(ST_MAINT);
      cell_set <= 12'h834;
      ws(ST_LCC);
      // Li-Ion select floating: done, then restart when discharged
      cfg(5'h0d, 12'hab9);
      cs_set <= 12'h8fc;
      ws(ST_DONE);
      cell_set <= 12'h834;
      ws(ST_LCC);
      $display("li-ion sequence done");
      end_sim;
   end
endmodule

//--- bench/bcs_stage_model.sv
// Behavioural power stage with battery pack and sense front end.
// Assumes the bench sets cell and current levels; all moves on pclk.
`timescale 1ns/1ps
module bcs_stage_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        discharge_drive,
   input  wire logic [11:0] cell_set,
   input  wire logic [11:0] cs_set,
   output logic      [11:0] cell_voltage_sense,
   output logic      [11:0] current_sense
);
   logic [11:0] last_r;
   // Load sags 1 mV a cycle, far faster than a real pack, to keep runs short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_voltage_sense <= 12'h000;
         last_r             <= 12'h000;
      end else if (cell_set != last_r) begin
         cell_voltage_sense <= cell_set;
         last_r             <= cell_set;
      end else if (discharge_drive && cell_voltage_sense != 12'h000) begin
         cell_voltage_sense <= cell_voltage_sense - 12'h001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) current_sense <= 12'h9c4;
      else current_sense <= cs_set;
   end
endmodule

//--- common/bcs_pkg.sv
// Shared constants and types for the battery charge sequencer.
// Assumes a 100 MHz pclk and converter codes scaled 1 LSB = 1 mV.
package bcs_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned SOFT_START_MIN = 5;
   localparam int unsigned QUAL_MIN       = 1;
   localparam int unsigned FAST_PWM_HZ    = 250;
   localparam int unsigned SLOW_PWM_DHZ   = 1;   // 0.1 Hz, in tenths of Hz
   localparam int unsigned PWM_STEPS      = 256;

   localparam logic [39:0] SOFT_CYC =
      40'(SOFT_START_MIN * 60) * 40'(CLK_HZ);
   localparam logic [39:0] QUAL_CYC =
      40'(QUAL_MIN * 60) * 40'(CLK_HZ);
   localparam logic [31:0] FAST_STEP_CYC =
      32'(CLK_HZ / (FAST_PWM_HZ * PWM_STEPS));
   localparam logic [31:0] SLOW_STEP_CYC =
      32'((64'(CLK_HZ) * 64'd10) / (64'(SLOW_PWM_DHZ) * 64'(PWM_STEPS)));

   // Thresholds in millivolts
   localparam logic [11:0] MV_MAX_NI     = 12'hbc9;  // 3017
   localparam logic [11:0] MV_GOOD       = 12'h4b0;  // 1200
   localparam logic [11:0] MV_PRESENT    = 12'h3e8;  // 1000
   localparam logic [11:0] MV_DISCHARGED = 12'h6a4;  // 1700
   localparam logic [11:0] MV_LI_41      = 12'ha73;  // 2675
   localparam logic [11:0] MV_LI_42      = 12'hab4;  // 2740
   localparam logic [11:0] MV_RESTART    = 12'h869;  // 2153
   localparam logic [11:0] MV_CS_LOW_I   = 12'h8fc;  // 2300
   localparam logic [11:0] MV_NDV_NICD   = 12'h032;  // 50
   localparam logic [11:0] MV_NDV_NIMH   = 12'h011;  // 17

   localparam logic [8:0]  DUTY_FULL  = 9'h100;
   localparam logic [8:0]  DUTY_FIFTH = 9'h033;
   localparam logic [8:0]  DUTY_MAINT = 9'h008;
   localparam logic [8:0]  DUTY_OFF   = 9'h000;

   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_ERR    = 12'h008;
   localparam logic [11:0] ADDR_LEVEL  = 12'h00c;
   localparam logic [1:0]  CTRL_RST    = 2'h3;
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_TEMP_BIT = 1;
   localparam int          ERR_OVERV = 0;
   localparam int          ERR_BAD   = 1;
   localparam int          ERR_TEMP  = 2;
   localparam logic [7:0]  SYNC_RST  = 8'h00;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001, ST_DISCH = 11'h002, ST_SOFT = 11'h004,
      ST_FAST = 11'h008, ST_TOPUP = 11'h010, ST_MAINT = 11'h020,
      ST_QUAL = 11'h040, ST_LCC   = 11'h080, ST_LCV   = 11'h100,
      ST_DONE = 11'h200, ST_ERR   = 11'h400
   } bcs_state_type;

   typedef enum logic [1:0] {
      LVL_LOW = 2'h0, LVL_HIGH = 2'h1, LVL_FLOAT = 2'h2
   } bcs_level_type;
endpackage

//--- core/bcs_charger.sv
// Charge sequencer for nickel and lithium packs with an APB register port.
// Assumes cell and current codes in mV arrive on pclk from a converter.
`timescale 1ns/1ps
module bcs_charger #(
   parameter logic [39:0] SOFT_CYC_P      = bcs_pkg::SOFT_CYC,
   parameter logic [39:0] QUAL_CYC_P      = bcs_pkg::QUAL_CYC,
   parameter logic [31:0] SLOW_STEP_CYC_P = bcs_pkg::SLOW_STEP_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        discharge_maint_select_pd,
   input  wire logic        discharge_maint_select_pu,
   input  wire logic        chemistry_select_pd,
   input  wire logic        chemistry_select_pu,
   input  wire logic        supply_or_cell_select,
   input  wire logic        timeout_rc_select,
   input  wire logic        temp_over,
   input  wire logic        temp_in_window,
   input  wire logic [11:0] cell_voltage_sense,
   input  wire logic [11:0] current_sense,
   output logic             pwm_out,
   output logic             discharge_drive
);
   import bcs_pkg::*;

   logic [7:0]    pin_s;
   logic          dm_pd_s, dm_pu_s, ch_pd_s, ch_pu_s;
   logic          supply_or_cell_select_s, rc_done_s, t_over_s, t_win_s;
   bcs_level_type dm_lvl, chem_lvl;
   logic          is_li, fast_rate, present, temp_ok, soft_done, qual_done;
   logic          ndv_hit, release_err, acc, setup;
   logic [11:0]   cel_r, cs_r, peak_r, li_target, ndv_lim;
   logic [39:0]   timer_r;
   logic [31:0]   pre_r, step;
   logic [7:0]    phase_r;
   logic [8:0]    duty;
   logic [1:0]    ctrl_r;
   logic [2:0]    err_flags_r, err_set;
   logic          temp_err_r;
   logic [31:0]   prdata_r;
   bcs_state_type state_r, state_nxt;

   bcs_sync #(.W(8)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({temp_in_window, temp_over, timeout_rc_select,
                  supply_or_cell_select, chemistry_select_pu,
                  chemistry_select_pd, discharge_maint_select_pu,
                  discharge_maint_select_pd}),
      .sync_out (pin_s)
   );

   assign {t_win_s, t_over_s, rc_done_s, supply_or_cell_select_s,
           ch_pu_s, ch_pd_s, dm_pu_s, dm_pd_s} = pin_s;

   // Pin is probed with a weak pull-down and a weak pull-up in turn
   function automatic bcs_level_type resolve(input logic pd, input logic pu);
      if (pd && pu) begin
         return LVL_HIGH;
      end else if (!pd && !pu) begin
         return LVL_LOW;
      end else begin
         return LVL_FLOAT;
      end
   endfunction

   assign dm_lvl    = resolve(dm_pd_s, dm_pu_s);
   assign chem_lvl  = resolve(ch_pd_s, ch_pu_s);
   assign is_li     = (chem_lvl == LVL_FLOAT);
   assign fast_rate = is_li | supply_or_cell_select_s;
   assign li_target = supply_or_cell_select_s ? MV_LI_42 : MV_LI_41;
   assign ndv_lim   = (chem_lvl == LVL_HIGH) ? MV_NDV_NIMH
                                             : MV_NDV_NICD;
   assign present   = (cel_r >= MV_PRESENT);
   assign temp_ok   = !ctrl_r[CTRL_TEMP_BIT] | t_win_s;
   assign soft_done = (timer_r >= SOFT_CYC_P - 40'd1);
   assign qual_done = (timer_r >= QUAL_CYC_P - 40'd1);
   assign ndv_hit   = (peak_r > cel_r) && ((peak_r - cel_r) >= ndv_lim);
   // A window flag alone is not enough: over-temperature must have cleared
   assign release_err = !present
                        || (temp_err_r && temp_ok && !t_over_s);

   // Converter codes are sampled so all comparisons see one value per edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cel_r <= 12'h000;
         cs_r  <= 12'h000;
      end else begin
         cel_r <= cell_voltage_sense;
         cs_r  <= current_sense;
      end
   end

   always_comb begin
      state_nxt = state_r;
      err_set   = 3'h0;
      case (state_r)
         ST_IDLE: begin
            if (present && ctrl_r[CTRL_EN_BIT] && temp_ok) begin
               if (is_li) begin
                  state_nxt = ST_QUAL;
               end else if (dm_lvl == LVL_LOW) begin
                  state_nxt = ST_MAINT;
               end else if (dm_lvl == LVL_FLOAT) begin
                  state_nxt = ST_DISCH;
               end else begin
                  state_nxt = ST_SOFT;
               end
            end
         end
         ST_DISCH: begin
            if (cel_r < MV_DISCHARGED) begin
               state_nxt = ST_SOFT;
            end
         end
         ST_SOFT: begin
            if (cel_r > MV_MAX_NI) begin
               state_nxt = ST_ERR;
               err_set[ERR_OVERV] = 1'b1;
            end else if (soft_done) begin
               if (cel_r < MV_GOOD) begin
                  state_nxt = ST_ERR;
                  err_set[ERR_BAD] = 1'b1;
               end else begin
                  state_nxt = ST_FAST;
               end
            end
         end
         ST_FAST: begin
            if (t_over_s) begin
               state_nxt = ST_ERR;
               err_set[ERR_TEMP] = 1'b1;
            end else if (cel_r > MV_MAX_NI) begin
               state_nxt = ST_ERR;
               err_set[ERR_OVERV] = 1'b1;
            end else if (ndv_hit) begin
               state_nxt = ST_TOPUP;
            end
         end
         ST_TOPUP: begin
            if (rc_done_s) begin
               state_nxt = ST_MAINT;
            end
         end
         ST_QUAL: begin
            if (qual_done) begin
               if (cel_r < MV_GOOD) begin
                  state_nxt = ST_ERR;
                  err_set[ERR_BAD] = 1'b1;
               end else begin
                  state_nxt = ST_LCC;
               end
            end
         end
         ST_LCC: begin
            if (t_over_s) begin
               state_nxt = ST_ERR;
               err_set[ERR_TEMP] = 1'b1;
            end else if (cel_r >= li_target) begin
               state_nxt = ST_LCV;
            end
         end
         ST_LCV: begin
            if (t_over_s) begin
               state_nxt = ST_ERR;
               err_set[ERR_TEMP] = 1'b1;
            end else if (cs_r >= MV_CS_LOW_I) begin
               state_nxt = (dm_lvl == LVL_FLOAT) ? ST_DONE : ST_MAINT;
            end
         end
         ST_MAINT: begin
            if (is_li && dm_lvl == LVL_LOW && cel_r < MV_RESTART) begin
               state_nxt = ST_LCC;
            end
         end
         ST_DONE: begin
            if (is_li && dm_lvl == LVL_FLOAT && cel_r < MV_RESTART) begin
               state_nxt = ST_LCC;
            end
         end
         ST_ERR: begin
            if (release_err) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Removal wins over every phase decision; in the error hold it acts through release_err
      if (!present && state_r != ST_ERR && state_r != ST_IDLE) begin
         state_nxt = ST_IDLE;
         err_set   = 3'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_r <= 40'h0;
      end else if (state_nxt != state_r) begin
         timer_r <= 40'h0;
      end else if (timer_r != 40'hff_ffff_ffff) begin
         timer_r <= timer_r + 40'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peak_r <= 12'h000;
      end else if (state_r != ST_FAST || cel_r > peak_r) begin
         peak_r <= cel_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_err_r <= 1'b0;
      end else if (state_r != ST_ERR) begin
         temp_err_r <= err_set[ERR_TEMP];
      end
   end

   // Duty in 1/256 steps; constant-voltage phase gates on cell level
   always_comb begin
      case (state_r)
         ST_FAST, ST_LCC: duty = DUTY_FULL;
         ST_LCV:  duty = (cel_r < li_target) ? DUTY_FULL : DUTY_OFF;
         ST_SOFT, ST_TOPUP, ST_QUAL: duty = DUTY_FIFTH;
         ST_MAINT: duty = DUTY_MAINT;
         default: duty = DUTY_OFF;
      endcase
   end

   assign step = fast_rate ? FAST_STEP_CYC : SLOW_STEP_CYC_P;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r   <= 32'h0;
         phase_r <= 8'h00;
      end else if (pre_r >= step - 32'h1) begin
         pre_r   <= 32'h0;
         phase_r <= phase_r + 8'h01;
      end else begin
         pre_r   <= pre_r + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out         <= 1'b0;
         discharge_drive <= 1'b0;
      end else begin
         pwm_out         <= ({1'b0, phase_r} < duty);
         discharge_drive <= (state_r == ST_DISCH);
      end
   end

   // APB slave, zero wait states
   assign setup   = psel && !penable;
   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = acc && paddr != ADDR_CTRL && paddr != ADDR_STATUS
                    && paddr != ADDR_ERR && paddr != ADDR_LEVEL;
   assign prdata  = prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
      end else if (acc && pwrite && paddr == ADDR_CTRL) begin
         ctrl_r <= pwdata[1:0];
      end
   end

   // Hardware set wins over a same-cycle write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_flags_r <= 3'h0;
      end else if (acc && pwrite && paddr == ADDR_ERR) begin
         err_flags_r <= (err_flags_r & ~pwdata[2:0]) | err_set;
      end else begin
         err_flags_r <= err_flags_r | err_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (setup && !pwrite) begin
         case (paddr)
            ADDR_CTRL:   prdata_r <= {30'h0, ctrl_r};
            ADDR_STATUS: prdata_r <= {15'h0, chem_lvl, dm_lvl,
                                      supply_or_cell_select_s, fast_rate, 11'h0} |
                                     {21'h0, state_r};
            ADDR_ERR:    prdata_r <= {29'h0, err_flags_r};
            ADDR_LEVEL:  prdata_r <= {4'h0, cs_r, 4'h0, cel_r};
            default:     prdata_r <= 32'h0;
         endcase
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_soft_overv;
      state_r == ST_SOFT && present && cel_r > MV_MAX_NI |=> state_r == ST_ERR;
   endproperty
   a_soft_overv: assert property (p_soft_overv)
      else $error("soft start overvoltage not trapped");

   property p_fast_temp;
      state_r == ST_FAST && present && t_over_s |=> state_r == ST_ERR;
   endproperty
   a_fast_temp: assert property (p_fast_temp)
      else $error("fast charge ignored over-temperature");

   property p_qual_bad;
      state_r == ST_QUAL && present && qual_done && cel_r < MV_GOOD
         |=> state_r == ST_ERR ##1 state_r == ST_ERR;
   endproperty
   a_qual_bad: assert property (p_qual_bad)
      else $error("bad Li-Ion cell not trapped");

   property p_cc_to_cv;
      state_r == ST_LCC && present && !t_over_s && cel_r >= li_target
         |=> state_r == ST_LCV;
   endproperty
   a_cc_to_cv: assert property (p_cc_to_cv)
      else $error("constant current did not end at target");

   property p_cv_end;
      state_r == ST_LCV && present && !t_over_s && cs_r >= MV_CS_LOW_I
         |=> state_r inside {ST_MAINT, ST_DONE};
   endproperty
   a_cv_end: assert property (p_cv_end)
      else $error("constant voltage did not end at low current");

   property p_dis_drive;
      discharge_drive |-> $past(state_r) == ST_DISCH;
   endproperty
   a_dis_drive: assert property (p_dis_drive)
      else $error("discharge drive outside discharge");

   property p_err_hold;
      state_r == ST_ERR && !release_err |=> state_r == ST_ERR;
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("error state left early");

   property p_idle_quiet;
      state_r == ST_IDLE ##1 state_r == ST_IDLE |-> !pwm_out && !discharge_drive;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("outputs active while idle");

   property p_soft_to_fast;
      state_r == ST_SOFT && present && soft_done && cel_r >= MV_GOOD
         && cel_r <= MV_MAX_NI |=> state_r == ST_FAST;
   endproperty
   a_soft_to_fast: assert property (p_soft_to_fast)
      else $error("soft start did not advance");

   c_cv: cover property (state_r == ST_LCC ##1 state_r == ST_LCV);
   c_top: cover property (state_r == ST_TOPUP ##1 state_r == ST_MAINT);
   c_err: cover property (state_r != ST_ERR ##1 state_r == ST_ERR);
   c_dis: cover property (state_r == ST_DISCH ##1 state_r == ST_SOFT);
endmodule

//--- core/bcs_sync.sv
// Three-stage synchroniser for pin inputs, with agreement filter.
// Assumes inputs are static levels; output moves when stages 2 and 3 agree.
`timescale 1ns/1ps
module bcs_sync #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   import bcs_pkg::*;
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= W'(SYNC_RST);
         s2_r <= W'(SYNC_RST);
         s3_r <= W'(SYNC_RST);
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // First stage feeds only the second; filter looks at stages 2 and 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_out <= W'(SYNC_RST);
      end else begin
         sync_out <= (s2_r & s3_r) | (sync_out & (s2_r ^ s3_r));
      end
   end
endmodule
